// ### rtl/jbs_tap.sv
`timescale 1ns/1ns
`default_nettype none
module jbs_tap (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic [jbs_pkg::BSR_LEN-1:0] ring_i,
   input wire logic [jbs_pkg::BSR_LEN-1:0] used_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic outs_float_o,
   output logic ring_drive_o,
   output logic [jbs_pkg::BSR_LEN-1:0] ring_o,
   output logic [jbs_pkg::FIFO_W-1:0] byte_o,
   output logic byte_valid_o,
   input wire logic byte_ready_i,
   output logic [jbs_pkg::IR_LEN-1:0] instr_o
);
   // ---------------------------------------------------------------
   // pin synchroniser and edge finding
   // ---------------------------------------------------------------
   jbs_pkg::jbs_link_t meta_ff;
   jbs_pkg::jbs_link_t sync_ff;
   logic tck_old_ff;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
         tck_old_ff <= 1'b0;
      end else begin
         meta_ff <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
         sync_ff <= meta_ff;
         tck_old_ff <= sync_ff.tck;
      end
   end
   wire rise = sync_ff.tck && !tck_old_ff;
   wire fall = !sync_ff.tck && tck_old_ff;
   // ---------------------------------------------------------------
   // state machine
   // ---------------------------------------------------------------
   jbs_pkg::jbs_state_t st_ff;
   jbs_pkg::jbs_state_t nxt_st;
   logic m;
   always_comb begin
      m = sync_ff.tms;
      case (st_ff)
         jbs_pkg::TLR: nxt_st = m ? jbs_pkg::TLR : jbs_pkg::RTI;
         jbs_pkg::RTI: nxt_st = m ? jbs_pkg::SEL_DR : jbs_pkg::RTI;
         jbs_pkg::SEL_DR: nxt_st = m ? jbs_pkg::SEL_IR : jbs_pkg::CAP_DR;
         jbs_pkg::CAP_DR: nxt_st = m ? jbs_pkg::EX1_DR : jbs_pkg::SH_DR;
         jbs_pkg::SH_DR: nxt_st = m ? jbs_pkg::EX1_DR : jbs_pkg::SH_DR;
         jbs_pkg::EX1_DR: nxt_st = m ? jbs_pkg::UPD_DR : jbs_pkg::PA_DR;
         jbs_pkg::PA_DR: nxt_st = m ? jbs_pkg::EX2_DR : jbs_pkg::PA_DR;
         jbs_pkg::EX2_DR: nxt_st = m ? jbs_pkg::UPD_DR : jbs_pkg::SH_DR;
         jbs_pkg::UPD_DR: nxt_st = m ? jbs_pkg::SEL_DR : jbs_pkg::RTI;
         jbs_pkg::SEL_IR: nxt_st = m ? jbs_pkg::TLR : jbs_pkg::CAP_IR;
         jbs_pkg::CAP_IR: nxt_st = m ? jbs_pkg::EX1_IR : jbs_pkg::SH_IR;
         jbs_pkg::SH_IR: nxt_st = m ? jbs_pkg::EX1_IR : jbs_pkg::SH_IR;
         jbs_pkg::EX1_IR: nxt_st = m ? jbs_pkg::UPD_IR : jbs_pkg::PA_IR;
         jbs_pkg::PA_IR: nxt_st = m ? jbs_pkg::EX2_IR : jbs_pkg::PA_IR;
         jbs_pkg::EX2_IR: nxt_st = m ? jbs_pkg::UPD_IR : jbs_pkg::SH_IR;
         jbs_pkg::UPD_IR: nxt_st = m ? jbs_pkg::SEL_DR : jbs_pkg::RTI;
         default: nxt_st = jbs_pkg::TLR;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) st_ff <= jbs_pkg::TLR;
      else if (rise) st_ff <= nxt_st;
   end
   // ---------------------------------------------------------------
   // instruction decode
   // ---------------------------------------------------------------
   logic [jbs_pkg::IR_LEN-1:0] ir_sh_ff;
   logic [jbs_pkg::IR_LEN-1:0] ir_ff;
   wire sel_id = ir_ff == jbs_pkg::INS_IDCODE;
   wire sel_bsr = ir_ff == jbs_pkg::INS_EXTEST || ir_ff == jbs_pkg::INS_SAMPLE
      || ir_ff == jbs_pkg::INS_HIGHZ;
   // clamp, bypass and reserved codes fall to bypass
   wire sel_byp = !sel_id && !sel_bsr;
   wire is_highz = ir_ff == jbs_pkg::INS_HIGHZ;
   wire is_drive = ir_ff == jbs_pkg::INS_EXTEST || ir_ff == jbs_pkg::INS_CLAMP;
   wire [jbs_pkg::ID_LEN-1:0] id_word = {jbs_pkg::ID_REV, jbs_pkg::ID_DEV,
      jbs_pkg::ID_VEND, jbs_pkg::ID_PRESENT};
   // ---------------------------------------------------------------
   // scan registers
   // ---------------------------------------------------------------
   logic byp_ff;
   logic [jbs_pkg::ID_LEN-1:0] id_sh_ff;
   logic [jbs_pkg::BSR_LEN-1:0] bsr_ff;
   logic [jbs_pkg::BSR_LEN-1:0] ring_ff;
   wire [jbs_pkg::BSR_LEN-1:0] ring_cap = ring_i & used_i;
   wire cap_dr = rise && st_ff == jbs_pkg::CAP_DR;
   wire sh_dr = rise && st_ff == jbs_pkg::SH_DR;
   always_ff @(posedge clk_i) begin
      if (reset_i || (rise && st_ff == jbs_pkg::TLR)) begin
         ir_ff <= jbs_pkg::INS_IDCODE;
         ir_sh_ff <= '0;
      end else if (rise && st_ff == jbs_pkg::CAP_IR) begin
         ir_sh_ff <= {ir_ff[7:2], jbs_pkg::IR_CAPT};
      end else if (rise && st_ff == jbs_pkg::SH_IR) begin
         ir_sh_ff <= {sync_ff.tdi, ir_sh_ff[7:1]};
      end else if (rise && st_ff == jbs_pkg::UPD_IR) begin
         ir_ff <= ir_sh_ff;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         byp_ff <= 1'b0;
         id_sh_ff <= '0;
         bsr_ff <= '0;
      end else if (cap_dr) begin
         byp_ff <= 1'b0;
         id_sh_ff <= id_word;
         bsr_ff <= ring_cap;
      end else if (sh_dr) begin
         byp_ff <= sync_ff.tdi;
         id_sh_ff <= {sync_ff.tdi, id_sh_ff[31:1]};
         bsr_ff <= {sync_ff.tdi, bsr_ff[112:1]};
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) ring_ff <= '0;
      else if (rise && st_ff == jbs_pkg::UPD_DR && sel_bsr) ring_ff <= bsr_ff & used_i;
   end
   // ---------------------------------------------------------------
   // serial output on falling edge
   // ---------------------------------------------------------------
   wire in_sh_ir = st_ff == jbs_pkg::SH_IR;
   wire in_sh_dr = st_ff == jbs_pkg::SH_DR;
   wire dr_bit = sel_id ? id_sh_ff[0] : (sel_bsr ? bsr_ff[0] : byp_ff);
   wire nxt_tdo = in_sh_ir ? ir_sh_ff[0] : dr_bit;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (fall) begin
         tdo_o <= nxt_tdo;
         tdo_oe_o <= in_sh_ir || in_sh_dr;
      end
   end
   // ---------------------------------------------------------------
   // outputs and shifted-bit stream
   // ---------------------------------------------------------------
   logic [jbs_pkg::FIFO_W-1:0] acc_ff;
   logic [2:0] nbit_ff;
   logic push_ff;
   logic [jbs_pkg::FIFO_W-1:0] pbyte_ff;
   logic in_ready;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_ff <= '0;
         nbit_ff <= '0;
         push_ff <= 1'b0;
         pbyte_ff <= '0;
      end else begin
         if (push_ff && in_ready) push_ff <= 1'b0;
         if (sh_dr) begin
            acc_ff <= {dr_bit, acc_ff[7:1]};
            nbit_ff <= nbit_ff + 3'h1;
            if (nbit_ff == 3'h7) begin
               pbyte_ff <= {dr_bit, acc_ff[7:1]};
               push_ff <= 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         outs_float_o <= 1'b0;
         ring_drive_o <= 1'b0;
         ring_o <= '0;
         instr_o <= jbs_pkg::INS_IDCODE;
      end else begin
         outs_float_o <= is_highz;
         ring_drive_o <= is_drive;
         ring_o <= ring_ff;
         instr_o <= ir_ff;
      end
   end
   jbs_fifo #(
      .WIDTH(jbs_pkg::FIFO_W),
      .DEPTH(jbs_pkg::FIFO_D)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_data_i(pbyte_ff),
      .in_valid_i(push_ff),
      .in_ready_o(in_ready),
      .out_data_o(byte_o),
      .out_valid_o(byte_valid_o),
      .out_ready_i(byte_ready_i)
   );
endmodule : jbs_tap
`default_nettype wire

// ### pkg/jbs_pkg.sv
package jbs_pkg;
   // ---------------------------------------------------------------
   // scan register lengths and fifo size
   // ---------------------------------------------------------------
   localparam int IR_LEN = 8;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN = 113;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;
   // ---------------------------------------------------------------
   // instruction codes
   // ---------------------------------------------------------------
   localparam logic [7:0] INS_EXTEST = 8'h00;
   localparam logic [7:0] INS_IDCODE = 8'h21;
   localparam logic [7:0] INS_SAMPLE = 8'h05;
   localparam logic [7:0] INS_CLAMP = 8'h07;
   localparam logic [7:0] INS_HIGHZ = 8'h03;
   localparam logic [7:0] INS_BYPASS = 8'hff;
   localparam logic [1:0] IR_CAPT = 2'h1;
   // ---------------------------------------------------------------
   // identification fields
   // ---------------------------------------------------------------
   localparam logic [3:0] ID_REV = 4'h0;
   localparam logic [15:0] ID_DEV = 16'h0001;
   // arbitrary vendor value
   localparam logic [10:0] ID_VEND = 11'h155;
   localparam logic ID_PRESENT = 1'h1;
   // ---------------------------------------------------------------
   // port controller states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } jbs_state_t;
   // link pins after synchronising
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jbs_link_t;
endpackage : jbs_pkg

// ### rtl/jbs_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module jbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
   assign out_valid_o = cnt_ff != '0;
   assign out_data_o = mem_ff[rd_ff];
   always_ff @(posedge clk_i) begin
      if (push) mem_ff[wr_ff] <= in_data_i;
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop) rd_ff <= rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : jbs_fifo
`default_nettype wire

// ### verification/jbs_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module jbs_ctl_model (
   input wire logic clk_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i
);
   // ----
   // test clock stands low between frames
   // ----
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (5) @(posedge clk_i);
      tdo = tdo_i;
      tck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      tck_o <= 1'b0;
   endtask : step
   // data line not meaningful here: drive the inverse of the last bit
   task automatic nav(input logic tms);
      logic d;
      step(tms, ~tdi_o, d);
   endtask : nav
   task automatic tlr();
      repeat (5) nav(1'b1);
      nav(1'b0);
   endtask : tlr
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
         output logic [127:0] dout);
      dout = '0;
      nav(1'b1);
      if (ir) nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      nav(1'b1);
      nav(1'b0);
      // let the update reach the registered outputs
      repeat (3) @(posedge clk_i);
   endtask : scan
endmodule : jbs_ctl_model
`default_nettype wire

// ### verification/jbs_tap_properties.sv
`timescale 1ns/1ns
`default_nettype none
module jbs_tap_properties (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic tck_i,
   input wire logic tdo_o,
   input wire logic tdo_oe_o,
   input wire logic outs_float_o,
   input wire logic ring_drive_o,
   input wire logic [jbs_pkg::FIFO_W-1:0] byte_o,
   input wire logic byte_valid_o,
   input wire logic byte_ready_i,
   input wire logic [jbs_pkg::IR_LEN-1:0] instr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   logic drv_ins;
   assign drv_ins = instr_o == jbs_pkg::INS_EXTEST || instr_o == jbs_pkg::INS_CLAMP;
   chk_highz_float: assert property (
      (instr_o == jbs_pkg::INS_HIGHZ) [*2] |-> outs_float_o) else $error("float missing");
   chk_float_cause: assert property (
      outs_float_o |-> instr_o == jbs_pkg::INS_HIGHZ || $past(instr_o) == jbs_pkg::INS_HIGHZ)
      else $error("float without high-z");
   chk_float_nodrive: assert property (
      outs_float_o |-> !ring_drive_o) else $error("ring driven while floating");
   chk_reset_idcode: assert property (
      $fell(reset_i) |-> instr_o == jbs_pkg::INS_IDCODE && !tdo_oe_o && !tdo_o)
      else $error("bad state after reset");
   chk_ring_drive: assert property (
      drv_ins [*2] |-> ring_drive_o) else $error("ring drive missing");
   chk_ring_quiet: assert property (
      !drv_ins [*2] |-> !ring_drive_o) else $error("ring driven wrongly");
   chk_tdo_fall: assert property (
      $changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2)) else $error("tdo moved off fall");
   chk_byte_hold: assert property (
      byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o))
      else $error("byte dropped while stalled");
endmodule : jbs_tap_properties
`default_nettype wire

// ### verification/jbs_tap_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module jbs_tap_tb_top;
   logic clk_i, reset_i, tck, tms, tdi, tdo, tdo_oe, flt, drv, bv, br;
   logic [jbs_pkg::BSR_LEN-1:0] ring_i, used_i, ring_o;
   logic [7:0] bo, instr;
   logic [127:0] q;
   logic [31:0] idv;
   int err_count, cmp_count;
   jbs_tap dut (.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .ring_i(ring_i), .used_i(used_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .outs_float_o(flt),
      .ring_drive_o(drv), .ring_o(ring_o), .byte_o(bo), .byte_valid_o(bv),
      .byte_ready_i(br), .instr_o(instr));
   jbs_ctl_model m (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
   task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   // ----
   // scenarios
   // ----
   task automatic t_fifo();
      m.tlr();
      repeat (9) m.scan(1'b0, 32, '0, q);
      for (int i = 0; i < 32; i++) begin
         chk("byte_valid", 1'b1, bv);
         chk("byte", idv[8*(i%4)+:8], bo);
         br <= 1'b1;
         @(posedge clk_i);
         br <= 1'b0;
         @(posedge clk_i);
      end
      // last byte made while full waits and enters once room appears
      chk("byte_valid", 1'b1, bv);
      chk("held byte", idv[31:24], bo);
      br <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i);
      chk("fifo empty", 1'b0, bv);
   endtask : t_fifo
   task automatic t_codes();
      logic [7:0] c [6] = '{8'h00, 8'h21, 8'h05, 8'h07, 8'h03, 8'hff};
      for (int i = 0; i < 6; i++) begin
         m.scan(1'b1, 8, {120'h0, c[i]}, q);
         chk("ir capture", 2'h1, q[1:0]);
         chk("instr", c[i], instr);
         chk("float", c[i] == 8'h03, flt);
         chk("drive", c[i] == 8'h00 || c[i] == 8'h07, drv);
      end
   endtask : t_codes
   task automatic t_idcode();
      m.tlr();
      chk("instr", 8'h21, instr);
      m.scan(1'b0, 40, '1, q);
      chk("id", {8'hff, idv}, q[39:0]);
   endtask : t_idcode
   task automatic t_bypass();
      logic [7:0] c [3] = '{8'hff, 8'h07, 8'hff};
      for (int i = 0; i < 3; i++) begin
         m.scan(1'b1, 8, {120'h0, c[i]}, q);
         m.scan(1'b0, 9, 128'h1a5, q);
         chk("bypass", {8'ha5, 1'b0}, q[8:0]);
      end
   endtask : t_bypass
   task automatic t_highz();
      logic [120:0] d;
      d = {8'h96, ~ring_i};
      m.scan(1'b1, 8, 128'h3, q);
      chk("float", 1'b1, flt);
      m.scan(1'b0, 121, {7'h0, d}, q);
      chk("boundary", ring_i & used_i, q[112:0]);
      chk("boundary tail", d[7:0], q[120:113]);
      chk("ring", d[120:8] & used_i, ring_o);
   endtask : t_highz
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      reset_i = 1'b1;
      br = 1'b0;
      err_count = 0;
      cmp_count = 0;
      ring_i = {{17{1'b1}}, {3{32'h96c3_a55a}}};
      used_i = {{49{1'b1}}, {4{16'h7ffe}}};
      idv = {jbs_pkg::ID_REV, jbs_pkg::ID_DEV, jbs_pkg::ID_VEND, 1'b1};
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("instr", 8'h21, instr);
      chk("tdo enable", 1'b0, tdo_oe);
      t_fifo();
      t_codes();
      t_idcode();
      t_bypass();
      t_highz();
      print_verdict();
   end
   initial begin
      #2000000;
      err_count++;
      print_verdict();
   end
endmodule : jbs_tap_tb_top
bind jbs_tap jbs_tap_properties u_chk (.clk_i, .reset_i, .tck_i, .tdo_o, .tdo_oe_o,
   .outs_float_o, .ring_drive_o, .byte_o, .byte_valid_o, .byte_ready_i, .instr_o);
`default_nettype wire
